// ### include/jtag_config_defines.svh
// constants for the test-port configuration loader
`ifndef JTAG_CONFIG_DEFINES_SVH
`define JTAG_CONFIG_DEFINES_SVH
`define JCFG_IR_W 10
`define JCFG_DR_W 32
`define JCFG_IR_CAPTURE 10'h001
`define JCFG_OP_BYPASS 10'h3FF
`define JCFG_OP_IDCODE 10'h006
`define JCFG_OP_SAMPLE 10'h005
`define JCFG_OP_PROGRAM 10'h002
`define JCFG_OP_STATUS 10'h004
`define JCFG_OP_PARK 10'h2D0
`define JCFG_OP_RESUME 10'h2B0
`define JCFG_OP_IO_SETUP 10'h00D
`define JCFG_CFG_BITS 1024
`define JCFG_ID_VALUE 32'h1234_5679
`define JCFG_RESET_TMS_COUNT 5
`endif

// ### include/jtag_config_pkg.sv
// types for the test-port configuration loader
package jtag_config_pkg;
  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE, SEL_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SEL_IR, CAPTURE_IR, SHIFT_IR,
    EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } tap_state_t;
endpackage

// ### hdl/jtag_config_control.sv
// test-port configuration loader with tap controller
`timescale 1ns/100ps
`include "jtag_config_defines.svh"
// What this block does
// - bypass passes test data through one bit, one test clock late
// - one extra test clock after last bit runs initialization
// - bypass, id and sample run without disturbing configuration
// - pin setup after park lets test port drive the buffers
// - park forces active configuration controllers idle
// - resume re-engages a parked active controller
// - chip-wide clear and output enable never touch test logic
// - complete goes high after good test-port load, else low
// - complete is readable through the test port
// - chain enable output may serve as user pin
// - test-port load starts at once, aborting other modes
// - sample input on rise, drive output on fall, else float
// - chain enable output goes low after good load
module jtag_config_control
  import jtag_config_pkg::*;
#(
  parameter int CFG_BITS = `JCFG_CFG_BITS,
  parameter int PIN_W = 8,
  parameter bit CHAIN_OUT_USER = 1'b0,
  parameter logic [31:0] ID_VALUE = `JCFG_ID_VALUE // arbitrary value
)(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic chip_wide_clear_n,
  input wire logic chip_wide_output_enable,
  input wire logic [3:0] scheme_select,
  input wire logic [PIN_W-1:0] pin_sample,
  input wire logic user_io_out,
  input wire logic user_io_oe,
  output logic config_complete,
  output logic chain_enable_out_n,
  output logic chain_enable_out_oe,
  output logic active_ctrl_idle,
  output logic io_setup_en,
  output logic config_abort,
  output logic cfg_bit,
  output logic cfg_bit_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ************************************************************
  // pin synchronisers and test clock edges
  // ************************************************************
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [1:0] tdi_q;
  always_ff @(posedge sys_clk)
  begin
    tck_q <= {tck_q[1:0], tck};
    tms_q <= {tms_q[0], tms};
    tdi_q <= {tdi_q[0], tdi};
  end
  wire logic tck_rise = tck_q[1] & ~tck_q[2];
  wire logic tck_fall = ~tck_q[1] & tck_q[2];
  // ************************************************************
  // tap controller
  // ************************************************************
  tap_state_t state_q, state_d;
  always_comb
  begin
    unique case (state_q)
      TEST_RESET: state_d = tms_q[1] ? TEST_RESET : RUN_IDLE;
      RUN_IDLE: state_d = tms_q[1] ? SEL_DR : RUN_IDLE;
      SEL_DR: state_d = tms_q[1] ? SEL_IR : CAPTURE_DR;
      CAPTURE_DR: state_d = tms_q[1] ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: state_d = tms_q[1] ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: state_d = tms_q[1] ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: state_d = tms_q[1] ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: state_d = tms_q[1] ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: state_d = tms_q[1] ? SEL_DR : RUN_IDLE;
      SEL_IR: state_d = tms_q[1] ? TEST_RESET : CAPTURE_IR;
      CAPTURE_IR: state_d = tms_q[1] ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: state_d = tms_q[1] ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: state_d = tms_q[1] ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: state_d = tms_q[1] ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: state_d = tms_q[1] ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: state_d = tms_q[1] ? SEL_DR : RUN_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      state_q <= TEST_RESET;
    else if (tck_rise)
      state_q <= state_d;
  end
  // ************************************************************
  // instruction and data registers
  // ************************************************************
  logic [`JCFG_IR_W-1:0] ir_sr_q, ir_q;
  logic [`JCFG_DR_W-1:0] dr_sr_q;
  logic bypass_q;
  wire logic load_ir = tck_rise && state_q == UPDATE_IR;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ir_sr_q <= '0;
      ir_q <= `JCFG_OP_IDCODE;
    end
    else if (tck_rise)
    begin
      if (state_q == TEST_RESET)
        ir_q <= `JCFG_OP_IDCODE;
      else if (state_q == CAPTURE_IR)
        ir_sr_q <= `JCFG_IR_CAPTURE;
      else if (state_q == SHIFT_IR)
        ir_sr_q <= {tdi_q[1], ir_sr_q[`JCFG_IR_W-1:1]};
      else if (state_q == UPDATE_IR)
        ir_q <= ir_sr_q;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      dr_sr_q <= '0;
      bypass_q <= 1'b0;
    end
    else if (tck_rise && state_q == CAPTURE_DR)
    begin
      bypass_q <= 1'b0;
      unique case (ir_q)
        `JCFG_OP_IDCODE: dr_sr_q <= ID_VALUE;
        `JCFG_OP_SAMPLE: dr_sr_q <= 32'(pin_sample);
        `JCFG_OP_STATUS: dr_sr_q <= 32'(config_complete);
        default: dr_sr_q <= '0;
      endcase
    end
    else if (tck_rise && state_q == SHIFT_DR)
    begin
      bypass_q <= tdi_q[1];
      dr_sr_q <= {tdi_q[1], dr_sr_q[`JCFG_DR_W-1:1]};
    end
  end
  // ************************************************************
  // test data output on falling test clock
  // ************************************************************
  logic dr_bit;
  always_comb
  begin
    unique case (ir_q)
      `JCFG_OP_IDCODE, `JCFG_OP_SAMPLE, `JCFG_OP_STATUS: dr_bit = dr_sr_q[0];
      default: dr_bit = bypass_q;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= state_q == SHIFT_IR ? ir_sr_q[0] : dr_bit;
      tdo_oe <= state_q == SHIFT_IR || state_q == SHIFT_DR;
    end
  end
  // ************************************************************
  // configuration sequence
  // ************************************************************
  logic busy_q;
  logic [31:0] cnt_q;
  wire logic load_done = busy_q && cnt_q == 32'(CFG_BITS);
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      config_complete <= 1'b0;
      config_abort <= 1'b0;
      cfg_bit <= 1'b0;
      cfg_bit_valid <= 1'b0;
    end
    else
    begin
      config_abort <= 1'b0;
      cfg_bit_valid <= 1'b0;
      if (load_ir && ir_sr_q == `JCFG_OP_PROGRAM)
      begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        config_complete <= 1'b0;
        config_abort <= 1'b1;
      end
      else if (tck_rise && load_done)
      begin
        busy_q <= 1'b0;
        config_complete <= 1'b1;
      end
      else if (tck_rise && busy_q && state_q == SHIFT_DR &&
               ir_q == `JCFG_OP_PROGRAM)
      begin
        cnt_q <= cnt_q + 32'd1;
        cfg_bit <= tdi_q[1];
        cfg_bit_valid <= 1'b1;
      end
    end
  end
  // ************************************************************
  // active controller park and pin setup
  // ************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      active_ctrl_idle <= 1'b0;
    else if (load_ir && ir_sr_q == `JCFG_OP_PARK)
      active_ctrl_idle <= 1'b1;
    else if (load_ir && ir_sr_q == `JCFG_OP_RESUME)
      active_ctrl_idle <= 1'b0;
  end
  assign io_setup_en = active_ctrl_idle && ir_q == `JCFG_OP_IO_SETUP;
  assign chain_enable_out_n = CHAIN_OUT_USER ? user_io_out
                                             : !config_complete;
  assign chain_enable_out_oe = CHAIN_OUT_USER ? user_io_oe : 1'b1;
  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_bypass_shift;
    tck_rise && state_q == SHIFT_DR && ir_q == `JCFG_OP_BYPASS;
  endsequence
  property p_bypass_delay;
    s_bypass_shift |=> bypass_q == $past(tdi_q[1]);
  endproperty
  a_bypass_delay: assert property (p_bypass_delay)
    else $error("bypass bit not one clock late");
  property p_init_cycle;
    (tck_rise && load_done) |=> config_complete && !busy_q;
  endproperty
  a_init_cycle: assert property (p_init_cycle)
    else $error("extra clock did not initialize");
  property p_id_keeps_load;
    (load_ir && busy_q && ir_sr_q == `JCFG_OP_IDCODE) |=> busy_q;
  endproperty
  a_id_keeps_load: assert property (p_id_keeps_load)
    else $error("id instruction disturbed loading");
  property p_io_setup;
    (load_ir && active_ctrl_idle && ir_sr_q == `JCFG_OP_IO_SETUP) |=>
      io_setup_en;
  endproperty
  a_io_setup: assert property (p_io_setup)
    else $error("pin setup not enabled after park");
  property p_park;
    (load_ir && ir_sr_q == `JCFG_OP_PARK) |=> active_ctrl_idle;
  endproperty
  a_park: assert property (p_park)
    else $error("park did not idle controller");
  property p_resume;
    (load_ir && ir_sr_q == `JCFG_OP_RESUME) |=> !active_ctrl_idle;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not re-engage");
  property p_complete_cause;
    $rose(config_complete) |-> $past(load_done && tck_rise);
  endproperty
  a_complete_cause: assert property (p_complete_cause)
    else $error("complete rose without full load");
  property p_abort;
    (load_ir && ir_sr_q == `JCFG_OP_PROGRAM) |=>
      config_abort && !config_complete ##1 !config_abort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("load did not start at once");
  property p_tdo_fall;
    $changed(tdo_oe) |-> $past(tck_fall);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("output enable moved off falling edge");
  property p_chain_out;
    (tck_rise && load_done && !CHAIN_OUT_USER) |=> !chain_enable_out_n;
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("chain enable out wrong");
  sequence s_tms_high_rises;
    (tck_rise && tms_q[1])[*1] ##1 (!tck_rise && tms_q[1])[*1];
  endsequence
  property p_sel_ir_reset;
    (state_q == SEL_IR) ##0 s_tms_high_rises |-> state_q == TEST_RESET;
  endproperty
  a_sel_ir_reset: assert property (p_sel_ir_reset)
    else $error("tap missed reset from select ir");
endmodule // jtag_config_control

// ### dv/jtag_host_model.sv
// host model driving the test port of the configuration loader
`timescale 1ns/100ps
module jtag_host_model (
  input wire logic sys_clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // ********************************
  // test port sequencing
  // ********************************
  logic oe_all;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    oe_all = 1'b1;
  end
  // one tck period, tdo taken just before the rise
  task automatic clk(input logic m, input logic d, output logic q);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (20) @(negedge sys_clk);
    q = tdo_oe ? tdo : !tdo;
    tck = 1'b1;
    repeat (20) @(negedge sys_clk);
    tck = 1'b0;
  endtask
  task automatic reset_tap();
    logic q;
    repeat (5) clk(1'b1, 1'b1, q);
    clk(1'b0, 1'b1, q);
    tms = 1'b1;
  endtask
  // from idle: shift n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    oe_all = 1'b1;
    clk(1'b1, 1'b1, q);
    if (ir)
      clk(1'b1, 1'b1, q);
    clk(1'b0, 1'b1, q);
    clk(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      clk(i == n - 1, din[i], q);
      dout[i] = q;
      oe_all &= tdo_oe;
    end
    clk(1'b1, 1'b1, q);
    clk(1'b0, 1'b1, q);
    tms = 1'b1;
    tdi = 1'b1;
  endtask
endmodule // jtag_host_model

// ### dv/jtag_config_control_tb.sv
// self-checking bench for the test-port configuration loader
`timescale 1ns/100ps
`include "jtag_config_defines.svh"
module jtag_config_control_tb;
  // ********************************
  // harness
  // ********************************
  localparam logic [31:0] ID = 32'h0A5C_3E10; // arbitrary value
  logic sys_clk, reset_n, tck, tms, tdi, tdo, tdo_oe, clr_n, oe_in;
  logic [7:0] pins;
  logic complete, chain_n, chain_oe, idle, io_en, abort, cbit, cvalid;
  logic abort_seen;
  logic [31:0] cap, d;
  int valid_cnt, fail_count, tests_run, cycles;
  jtag_config_control #(.CFG_BITS(16), .PIN_W(8), .ID_VALUE(ID)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .chip_wide_clear_n(clr_n),
    .chip_wide_output_enable(oe_in), .scheme_select(4'h0),
    .pin_sample(pins), .user_io_out(1'b0), .user_io_oe(1'b0),
    .config_complete(complete), .chain_enable_out_n(chain_n),
    .chain_enable_out_oe(chain_oe), .active_ctrl_idle(idle),
    .io_setup_en(io_en), .config_abort(abort), .cfg_bit(cbit),
    .cfg_bit_valid(cvalid));
  jtag_host_model host (.sys_clk(sys_clk), .tdo(tdo), .tdo_oe(tdo_oe),
    .tck(tck), .tms(tms), .tdi(tdi));
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (abort === 1'b1)
      abort_seen = 1'b1;
    if (cvalid === 1'b1)
    begin
      valid_cnt++;
      cap = {cbit, cap[31:1]};
    end
    if (cycles == 60000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic ir(input logic [9:0] op);
    host.scan(1'b1, `JCFG_IR_W, {22'h0, op}, d);
    chk(d, 32'(`JCFG_IR_CAPTURE));
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic test_idcode();
    host.scan(1'b0, 32, 32'h0, d);
    chk(d, ID);
    chk_bit(host.oe_all, 1'b1);
    chk_bit(tdo_oe, 1'b0);
  endtask
  task automatic test_bypass();
    ir(`JCFG_OP_BYPASS);
    host.scan(1'b0, 8, 32'h0000_00B4, d);
    chk(d, 32'h0000_0068);
  endtask
  task automatic test_park();
    ir(`JCFG_OP_PARK);
    chk_bit(idle, 1'b1);
    ir(`JCFG_OP_IO_SETUP);
    chk_bit(io_en, 1'b1);
    ir(`JCFG_OP_RESUME);
    chk_bit(idle, 1'b0);
    chk_bit(io_en, 1'b0);
    host.reset_tap();
    host.scan(1'b0, 32, 32'h0, d);
    chk(d, ID);
  endtask
  task automatic test_load();
    clr_n = 1'b0;
    abort_seen = 1'b0;
    ir(`JCFG_OP_PROGRAM);
    chk_bit(abort_seen, 1'b1);
    host.scan(1'b0, 8, 32'h0000_005A, d);
    chk_bit(complete, 1'b0);
    ir(`JCFG_OP_IDCODE);
    host.scan(1'b0, 32, 32'h0, d);
    chk(d, ID);
    ir(`JCFG_OP_SAMPLE);
    host.scan(1'b0, 32, 32'h0, d);
    chk({24'h0, d[7:0]}, 32'h0000_00A5);
    chk_bit(complete, 1'b0);
    oe_in = 1'b1;
    ir(`JCFG_OP_PROGRAM);
    valid_cnt = 0;
    host.scan(1'b0, 16, 32'h0000_C3A5, d);
    chk(32'(valid_cnt), 32'h0000_0010);
    chk({16'h0, cap[31:16]}, 32'h0000_C3A5);
    chk_bit(complete, 1'b1);
    chk_bit(chain_n, 1'b0);
    chk_bit(chain_oe, 1'b1);
    ir(`JCFG_OP_STATUS);
    host.scan(1'b0, 32, 32'h0, d);
    chk_bit(d[0], 1'b1);
    clr_n = 1'b1;
    oe_in = 1'b0;
  endtask
  initial
  begin
    reset_n = 1'b0;
    clr_n = 1'b1;
    oe_in = 1'b0;
    pins = 8'hA5;
    cap = 32'h0;
    abort_seen = 1'b0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk_bit(complete, 1'b0);
    chk_bit(chain_n, 1'b1);
    chk_bit(tdo_oe, 1'b0);
    host.reset_tap();
    test_idcode();
    test_bypass();
    test_park();
    test_load();
    report_and_stop();
  end
endmodule // jtag_config_control_tb
